/* File: dv/integer_op_cycle_timing_tb.sv */
`timescale 1ns/1ps
module integer_op_cycle_timing_tb
   import op_timing_pkg::*;
;
   logic clk_i, resetn_i, req_valid_i, req_ready_o, done_o;
   logic rd_strobe_o, wr_strobe_o, pf_strobe_o;
   req_t req_i, q;
   res_t res_o;
   logic [7:0] rd_cnt, wr_cnt, pf_cnt;
   int n_errors, comparisons, seed, o, f, c;

   integer_op_cycle_timing dut_u (
      .clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i), .req_i(req_i),
      .req_ready_o(req_ready_o), .rd_strobe_o(rd_strobe_o), .wr_strobe_o(wr_strobe_o),
      .pf_strobe_o(pf_strobe_o), .done_o(done_o), .res_o(res_o));

   mem_bus_model mem_u (
      .clk_i(clk_i), .rd_strobe_i(rd_strobe_o), .wr_strobe_i(wr_strobe_o),
      .pf_strobe_i(pf_strobe_o), .rd_count_o(rd_cnt), .wr_count_o(wr_cnt),
      .pf_count_o(pf_cnt));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic test_done();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   task automatic chk_b(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %0b seen %0b", what, exp, got);
      end
   endtask : chk_b

   task automatic chk_v(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk_v

   function automatic logic [17:0] t3(input int x, input int y, input int z);
      return {6'(x), 6'(y), 6'(z)};
   endfunction : t3

   // Best, cache and worst totals per op and form, plus the memory-form add-on
   function automatic res_t expect_res(input req_t r);
      logic [17:0] t;
      logic m, ok;
      int rm, wm, ak;
      logic [4:0] add;
      res_t e;
      m = (r.form == FORM_MEM);
      ok = 1'b1;
      rm = 0;
      wm = 1;
      ak = 2;
      t = t3(0, 2, 3);
      case (r.op)
         OP_DECIMAL_ADD_WITH_EXTEND, OP_DECIMAL_SUBTRACT_WITH_EXTEND: begin
            t = m ? t3(14, 16, 17) : t3(4, 4, 5);
            rm = 2;
            ak = 0;
         end
         OP_BINARY_ADD_WITH_EXTEND, OP_BINARY_SUBTRACT_WITH_EXTEND: begin
            t = m ? t3(10, 12, 13) : t3(2, 2, 3);
            rm = 2;
            ak = 0;
         end
         OP_MEMORY_COMPARE_POSTINCREMENT: begin
            t = t3(8, 9, 10);
            {rm, wm, ak, ok} = {32'd2, 32'd0, 32'd0, m};
         end
         OP_DIGIT_COMPRESS, OP_DIGIT_EXPAND: begin
            t = m ? t3(11, 13, 13) : (r.op == OP_DIGIT_EXPAND ? t3(5, 8, 9) : t3(3, 6, 7));
            rm = 1;
            ak = 0;
         end
         OP_ZERO_OPERAND: {t, ak} = {m ? t3(3, 4, 6) : t3(0, 2, 3), 32'd1};
         OP_TWOS_COMPLEMENT_OPERAND, OP_TWOS_COMPLEMENT_WITH_EXTEND, OP_ONES_COMPLEMENT:
            t = m ? t3(3, 4, 6) : t3(0, 2, 3);
         OP_SIGN_WIDEN: {t, ok} = {t3(1, 4, 4), !m};
         OP_DECIMAL_COMPLEMENT: {t, ok} = {t3(6, 6, 6), !m};
         OP_SET_ON_CONDITION: {t, ak} = {m ? t3(6, 6, 6) : t3(1, 4, 4), 32'd1};
         OP_ATOMIC_TEST_SET: {t, rm, ak} = {m ? t3(12, 12, 13) : t3(1, 4, 4), 32'd1, 32'd1};
         OP_COMPARE_WITH_ZERO: wm = 0;
         OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT:
            t = m ? t3(5, 5, 6) : (r.form == FORM_DYN ? t3(3, 6, 6) : t3(1, 4, 4));
         OP_ARITH_LEFT_SHIFT: t = m ? t3(6, 6, 7) : t3(5, 8, 8);
         OP_ARITH_RIGHT_SHIFT: t = m ? t3(5, 5, 6) : t3(3, 6, 6);
         OP_LEFT_ROTATE, OP_RIGHT_ROTATE: t = m ? t3(7, 7, 7) : t3(5, 8, 8);
         OP_LEFT_ROTATE_THROUGH_EXTEND, OP_RIGHT_ROTATE_THROUGH_EXTEND:
            t = m ? t3(5, 5, 6) : t3(9, 12, 12);
         OP_SINGLE_BIT_TEST, OP_SINGLE_BIT_TOGGLE, OP_SINGLE_BIT_ZERO,
         OP_SINGLE_BIT_RAISE: begin
            t = m ? t3(4, 4, 5) : t3(1, 4, 5);
            ak = 3;
            wm = (r.op == OP_SINGLE_BIT_TEST) ? 0 : 1;
         end
         // Codes past the last operation carry no timing at all
         default: ok = 1'b0;
      endcase
      add = (ak == 1) ? r.ea_calc_clk : (ak == 2) ? r.ea_fetch_clk :
            (ak == 3) ? (r.bitnum_from_reg ? r.ea_fetch_clk : r.imm_fetch_clk) : 5'h00;
      e = '0;
      e.tcase = r.overlap ? CASE_BEST : (r.cache_hit ? CASE_CACHE : CASE_WORST);
      e.illegal = !ok;
      if (ok) begin
         e.clocks = t[17 - 6 * int'(e.tcase) -: 6] + (m ? 6'(add) : CLK_NONE);
         e.reads = m ? 2'(rm) : CNT_NONE;
         e.writes = m ? 2'(wm) : CNT_NONE;
         e.prefetches = (e.tcase == CASE_WORST) ? PF_WORST : CNT_NONE;
      end
      return e;
   endfunction : expect_res

   function automatic req_t rand_req();
      logic [31:0] x;
      logic [31:0] y;
      req_t r;
      x = $random(seed);
      y = $random(seed);
      r.op = op_t'(5'(x % 28));
      r.form = form_t'(2'(y % 3));
      {r.bitnum_from_reg, r.overlap, r.cache_hit} = x[10:8];
      {r.ea_calc_clk, r.ea_fetch_clk, r.imm_fetch_clk} = x[25:11];
      return r;
   endfunction : rand_req

   task automatic chk_idle();
      chk_b("ready", 1'b1, req_ready_o);
      chk_b("done", 1'b0, done_o);
      chk_v("strobes", 16'h0000, 16'({rd_strobe_o, wr_strobe_o, pf_strobe_o}));
      chk_v("result", 16'h0000, 16'(res_o));
   endtask : chk_idle

   // Take one request; with noise, requests are offered while busy and must be ignored
   task automatic run_op(input req_t r, input logic noise);
      res_t e;
      int k, nd, rc, wc, pc;
      logic [7:0] r0, w0, p0;
      logic [2:0] st;
      e = expect_res(r);
      nd = (e.illegal || e.clocks == CLK_NONE) ? 1 : int'(e.clocks) + 1;
      {rc, wc, pc} = {int'(e.reads), int'(e.writes), int'(e.prefetches)};
      {r0, w0, p0} = {rd_cnt, wr_cnt, pf_cnt};
      req_i = r;
      req_valid_i = 1'b1;
      @(posedge clk_i);
      #1 req_valid_i = 1'b0;
      for (k = 1; k <= nd; k++) begin
         st = {k <= rc, k > rc && k <= rc + wc, pc == 1 && k == rc + wc + 1};
         chk_b("ready", 1'b0, req_ready_o);
         chk_b("done", k == nd, done_o);
         chk_v("strobes", 16'(st), 16'({rd_strobe_o, wr_strobe_o, pf_strobe_o}));
         if (k == 1 || k == nd) begin
            chk_v("illegal", 16'(e.illegal), 16'(res_o.illegal));
            chk_v("clocks", 16'(e.clocks), 16'(res_o.clocks));
            if (!e.illegal) begin
               chk_v("tcase", 16'(e.tcase), 16'(res_o.tcase));
               chk_v("rpw", 16'({e.reads, e.prefetches, e.writes}),
                     16'({res_o.reads, res_o.prefetches, res_o.writes}));
            end
         end
         req_valid_i = noise && k < nd;
         if (noise) req_i = rand_req();
         @(posedge clk_i);
         #1;
      end
      chk_b("ready", 1'b1, req_ready_o);
      chk_v("bus", 16'({6'(rc), 6'(wc), 4'(pc)}),
            16'({6'(rd_cnt - r0), 6'(wr_cnt - w0), 4'(pf_cnt - p0)}));
   endtask : run_op

   initial begin
      repeat (40000) @(posedge clk_i);
      n_errors++;
      test_done();
   end

   initial begin
      seed = 32'hf583;
      n_errors = 0;
      comparisons = 0;
      resetn_i = 1'b0;
      req_valid_i = 1'b0;
      req_i = '0;
      repeat (10) @(posedge clk_i);
      #1 chk_idle();
      resetn_i = 1'b1;
      // The last four codes name no operation and must come back illegal
      for (o = 0; o < 32; o++) begin
         for (f = 0; f < 3; f++) begin
            for (c = 0; c < 3; c++) begin
               q = '0;
               q.op = op_t'(5'(o));
               q.form = form_t'(2'(f));
               {q.overlap, q.cache_hit} = {c == 0, c == 1};
               run_op(q, 1'b0);
            end
         end
      end
      repeat (300) begin
         q = rand_req();
         run_op(q, q.ea_calc_clk[0]);
      end
      q = '0;
      q.op = OP_DECIMAL_ADD_WITH_EXTEND;
      q.form = FORM_MEM;
      req_i = q;
      req_valid_i = 1'b1;
      @(posedge clk_i);
      #1 req_valid_i = 1'b0;
      repeat (3) @(posedge clk_i);
      #1 resetn_i = 1'b0;
      #1 chk_idle();
      @(posedge clk_i);
      #1 resetn_i = 1'b1;
      @(posedge clk_i);
      #1 chk_idle();
      run_op(q, 1'b0);
      test_done();
   end
endmodule : integer_op_cycle_timing_tb

/* File: dv/mem_bus_model.sv */
`timescale 1ns/1ps
// Far-side memory: tallies every bus cycle the block issues
module mem_bus_model (
   // Clock
   input wire logic clk_i,
   // Bus cycle strobes from the block
   input wire logic rd_strobe_i,
   input wire logic wr_strobe_i,
   input wire logic pf_strobe_i,
   // Free-running totals; the bench takes differences, so wrapping is harmless
   output logic [7:0] rd_count_o,
   output logic [7:0] wr_count_o,
   output logic [7:0] pf_count_o
);
   // One process owns each tally so the outputs have a single driver
   logic [7:0] rd_q = 8'h00;
   logic [7:0] wr_q = 8'h00;
   logic [7:0] pf_q = 8'h00;

   always @(posedge clk_i) begin
      rd_q <= rd_q + 8'(rd_strobe_i);
      wr_q <= wr_q + 8'(wr_strobe_i);
      pf_q <= pf_q + 8'(pf_strobe_i);
   end

   assign rd_count_o = rd_q;
   assign wr_count_o = wr_q;
   assign pf_count_o = pf_q;
endmodule : mem_bus_model

/* File: rtl/integer_op_cycle_timing.sv */
`timescale 1ns/1ps
// Function
// - Every clock total already contains the read, prefetch and write bus cycles it reports.
// - Decimal add/subtract register form takes 4, 4 and 5 clocks, worst adding a prefetch.
// - Decimal add/subtract predecrement form takes 14, 16 and 17 clocks, two reads, one write.
// - Binary add/subtract with extend takes 2/2/3 on registers and 10/12/13 on memory.
// - Postincrement memory compare takes 8, 9 and 10 clocks with two reads and no write.
// - Digit compress 3/6/7, expand 5/8/9 on registers, both 11/13/13 on memory.
// - Zeroing and complements take 0/2/3 on a register and 3/4/6 on memory with one write.
// - Sign widen 1/4/4, decimal complement 6 always, memory test-and-set 12/12/13.
// - Memory zero, set and test-and-set add address calculation; complements, compare with zero, shifts and rotates add address fetch.
// - Register shifts: logical 1/4/4 static, 3/6/6 dynamic, arith left 5/8/8, right 3/6/6.
// - Shift and rotate time never depends on the shift distance.
// - Register rotates take 5/8/8 and rotates through extend take 9/12/12.
// - Memory rotates by one take 7 always, through extend 5/5/6, both directions alike.
// - Memory shifts by one write once: logical and arith right 5/5/6, arith left 6/6/7.
// - Bit ops take 1/4/5 on a register and 4/4/5 on memory, writing once except test.
// - Memory bit ops add immediate fetch for an immediate bit number, else address fetch.
module integer_op_cycle_timing
   import op_timing_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Request
   input wire logic req_valid_i,
   input wire req_t req_i,
   output logic req_ready_o,
   // Bus cycle strobes
   output logic rd_strobe_o,
   output logic wr_strobe_o,
   output logic pf_strobe_o,
   // Result
   output logic done_o,
   output res_t res_o
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_DONE = 2'b10
   } state_t;

   // Shift distance is deliberately not an input: the table has no count term
   function automatic entry_t lookup(input op_t op, input form_t form);
      logic mem;
      entry_t e;
      mem = (form == FORM_MEM);
      e = '0;
      e.legal = 1'b1;
      unique case (op)
         OP_DECIMAL_ADD_WITH_EXTEND, OP_DECIMAL_SUBTRACT_WITH_EXTEND: begin
            if (mem) e = {1'b1, 5'h0e, 5'h10, 5'h11, 2'h2, 2'h1};
            else e = {1'b1, 5'h04, 5'h04, 5'h05, 2'h0, 2'h0};
         end
         OP_BINARY_ADD_WITH_EXTEND, OP_BINARY_SUBTRACT_WITH_EXTEND: begin
            if (mem) e = {1'b1, 5'h0a, 5'h0c, 5'h0d, 2'h2, 2'h1};
            else e = {1'b1, 5'h02, 5'h02, 5'h03, 2'h0, 2'h0};
         end
         OP_MEMORY_COMPARE_POSTINCREMENT: begin
            e = {mem, 5'h08, 5'h09, 5'h0a, 2'h2, 2'h0};
         end
         OP_DIGIT_COMPRESS: begin
            if (mem) e = {1'b1, 5'h0b, 5'h0d, 5'h0d, 2'h1, 2'h1};
            else e = {1'b1, 5'h03, 5'h06, 5'h07, 2'h0, 2'h0};
         end
         OP_DIGIT_EXPAND: begin
            if (mem) e = {1'b1, 5'h0b, 5'h0d, 5'h0d, 2'h1, 2'h1};
            else e = {1'b1, 5'h05, 5'h08, 5'h09, 2'h0, 2'h0};
         end
         OP_ZERO_OPERAND, OP_TWOS_COMPLEMENT_OPERAND, OP_TWOS_COMPLEMENT_WITH_EXTEND,
         OP_ONES_COMPLEMENT: begin
            if (mem) e = {1'b1, 5'h03, 5'h04, 5'h06, 2'h0, 2'h1};
            else e = {1'b1, 5'h00, 5'h02, 5'h03, 2'h0, 2'h0};
         end
         OP_SIGN_WIDEN: begin
            e = {!mem, 5'h01, 5'h04, 5'h04, 2'h0, 2'h0};
         end
         OP_DECIMAL_COMPLEMENT: begin
            e = {!mem, 5'h06, 5'h06, 5'h06, 2'h0, 2'h0};
         end
         OP_SET_ON_CONDITION: begin
            if (mem) e = {1'b1, 5'h06, 5'h06, 5'h06, 2'h0, 2'h1};
            else e = {1'b1, 5'h01, 5'h04, 5'h04, 2'h0, 2'h0};
         end
         OP_ATOMIC_TEST_SET: begin
            if (mem) e = {1'b1, 5'h0c, 5'h0c, 5'h0d, 2'h1, 2'h1};
            else e = {1'b1, 5'h01, 5'h04, 5'h04, 2'h0, 2'h0};
         end
         OP_COMPARE_WITH_ZERO: begin
            e = {1'b1, 5'h00, 5'h02, 5'h03, 2'h0, 2'h0};
         end
         OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT: begin
            if (mem) e = {1'b1, 5'h05, 5'h05, 5'h06, 2'h0, 2'h1};
            else if (form == FORM_DYN) e = {1'b1, 5'h03, 5'h06, 5'h06, 2'h0, 2'h0};
            else e = {1'b1, 5'h01, 5'h04, 5'h04, 2'h0, 2'h0};
         end
         OP_ARITH_LEFT_SHIFT: begin
            if (mem) e = {1'b1, 5'h06, 5'h06, 5'h07, 2'h0, 2'h1};
            else e = {1'b1, 5'h05, 5'h08, 5'h08, 2'h0, 2'h0};
         end
         OP_ARITH_RIGHT_SHIFT: begin
            if (mem) e = {1'b1, 5'h05, 5'h05, 5'h06, 2'h0, 2'h1};
            else e = {1'b1, 5'h03, 5'h06, 5'h06, 2'h0, 2'h0};
         end
         OP_LEFT_ROTATE, OP_RIGHT_ROTATE: begin
            if (mem) e = {1'b1, 5'h07, 5'h07, 5'h07, 2'h0, 2'h1};
            else e = {1'b1, 5'h05, 5'h08, 5'h08, 2'h0, 2'h0};
         end
         OP_LEFT_ROTATE_THROUGH_EXTEND, OP_RIGHT_ROTATE_THROUGH_EXTEND: begin
            if (mem) e = {1'b1, 5'h05, 5'h05, 5'h06, 2'h0, 2'h1};
            else e = {1'b1, 5'h09, 5'h0c, 5'h0c, 2'h0, 2'h0};
         end
         OP_SINGLE_BIT_TEST: begin
            if (mem) e = {1'b1, 5'h04, 5'h04, 5'h05, 2'h0, 2'h0};
            else e = {1'b1, 5'h01, 5'h04, 5'h05, 2'h0, 2'h0};
         end
         OP_SINGLE_BIT_TOGGLE, OP_SINGLE_BIT_ZERO, OP_SINGLE_BIT_RAISE: begin
            if (mem) e = {1'b1, 5'h04, 5'h04, 5'h05, 2'h0, 2'h1};
            else e = {1'b1, 5'h01, 5'h04, 5'h05, 2'h0, 2'h0};
         end
         default: e.legal = 1'b0;
      endcase
      return e;
   endfunction : lookup

   state_t state_q, state_d;
   res_t res_q, res_d;
   logic [CLK_W-1:0] rem_q, rem_d;
   logic [CNT_W-1:0] rd_left_q, rd_left_d;
   logic [CNT_W-1:0] wr_left_q, wr_left_d;
   logic [CNT_W-1:0] pf_left_q, pf_left_d;

   logic take;
   logic run;
   entry_t ent;
   case_t sel_case;
   logic [ADD_W-1:0] base_clk;
   logic [ADD_W-1:0] addon_clk;
   logic [CLK_W-1:0] total_clk;

   assign take = req_valid_i && (state_q == ST_IDLE);
   assign run = (state_q == ST_RUN);
   assign req_ready_o = (state_q == ST_IDLE);
   assign done_o = (state_q == ST_DONE);
   assign res_o = res_q;

   // Bus cycles are drawn from the counted total, reads first, prefetch last
   assign rd_strobe_o = run && (rd_left_q != CNT_NONE);
   assign wr_strobe_o = run && (rd_left_q == CNT_NONE) && (wr_left_q != CNT_NONE);
   assign pf_strobe_o = run && (rd_left_q == CNT_NONE) && (wr_left_q == CNT_NONE)
      && (pf_left_q != CNT_NONE);

   always_comb begin
      ent = lookup(req_i.op, req_i.form);
      // Overlap beats a cache hit, anything else goes to the external bus
      if (req_i.overlap) sel_case = CASE_BEST;
      else if (req_i.cache_hit) sel_case = CASE_CACHE;
      else sel_case = CASE_WORST;
      unique case (sel_case)
         CASE_BEST: base_clk = ent.best;
         CASE_CACHE: base_clk = ent.cache;
         default: base_clk = ent.worst;
      endcase
      addon_clk = '0;
      if (req_i.form == FORM_MEM) begin
         unique case (req_i.op)
            OP_ZERO_OPERAND, OP_SET_ON_CONDITION, OP_ATOMIC_TEST_SET:
               addon_clk = req_i.ea_calc_clk;
            OP_TWOS_COMPLEMENT_OPERAND, OP_TWOS_COMPLEMENT_WITH_EXTEND, OP_ONES_COMPLEMENT,
            OP_COMPARE_WITH_ZERO, OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
            OP_ARITH_LEFT_SHIFT, OP_ARITH_RIGHT_SHIFT, OP_LEFT_ROTATE, OP_RIGHT_ROTATE,
            OP_LEFT_ROTATE_THROUGH_EXTEND, OP_RIGHT_ROTATE_THROUGH_EXTEND:
               addon_clk = req_i.ea_fetch_clk;
            OP_SINGLE_BIT_TEST, OP_SINGLE_BIT_TOGGLE, OP_SINGLE_BIT_ZERO,
            OP_SINGLE_BIT_RAISE: begin
               // Bit number from a register costs an address fetch instead
               if (req_i.bitnum_from_reg) addon_clk = req_i.ea_fetch_clk;
               else addon_clk = req_i.imm_fetch_clk;
            end
            default: addon_clk = '0;
         endcase
      end
      total_clk = {1'b0, base_clk} + {1'b0, addon_clk};
   end

   always_comb begin
      state_d = state_q;
      res_d = res_q;
      rem_d = rem_q;
      rd_left_d = rd_left_q;
      wr_left_d = wr_left_q;
      pf_left_d = pf_left_q;
      unique case (state_q)
         ST_IDLE: begin
            if (take) begin
               res_d.illegal = !ent.legal;
               res_d.tcase = sel_case;
               res_d.clocks = ent.legal ? total_clk : CLK_NONE;
               res_d.reads = ent.legal ? ent.reads : CNT_NONE;
               res_d.writes = ent.legal ? ent.writes : CNT_NONE;
               // Only the worst case pays for the next prefetch
               res_d.prefetches = (ent.legal && sel_case == CASE_WORST) ? PF_WORST : CNT_NONE;
               rem_d = res_d.clocks;
               rd_left_d = res_d.reads;
               wr_left_d = res_d.writes;
               pf_left_d = res_d.prefetches;
               // An illegal pairing or a zero-clock case finishes without running
               state_d = (res_d.clocks == CLK_NONE) ? ST_DONE : ST_RUN;
            end
         end
         ST_RUN: begin
            rem_d = rem_q - CLK_ONE;
            if (rd_strobe_o) rd_left_d = rd_left_q - 2'h1;
            if (wr_strobe_o) wr_left_d = wr_left_q - 2'h1;
            if (pf_strobe_o) pf_left_d = pf_left_q - 2'h1;
            if (rem_q == CLK_ONE) state_d = ST_DONE;
         end
         ST_DONE: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= ST_IDLE;
         res_q <= '0;
         rem_q <= '0;
         rd_left_q <= '0;
         wr_left_q <= '0;
         pf_left_q <= '0;
      end else begin
         state_q <= state_d;
         res_q <= res_d;
         rem_q <= rem_d;
         rd_left_q <= rd_left_d;
         wr_left_q <= wr_left_d;
         pf_left_q <= pf_left_d;
      end
   end

   // Helper counts of issued strobes for the bus-cycle check
   logic [CNT_W-1:0] n_rd_q, n_wr_q, n_pf_q;
   logic [CNT_W-1:0] n_rd_d, n_wr_d, n_pf_d;
   always_comb begin
      n_rd_d = n_rd_q + CNT_W'(rd_strobe_o);
      n_wr_d = n_wr_q + CNT_W'(wr_strobe_o);
      n_pf_d = n_pf_q + CNT_W'(pf_strobe_o);
      if (take) begin
         n_rd_d = '0;
         n_wr_d = '0;
         n_pf_d = '0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         n_rd_q <= '0;
         n_wr_q <= '0;
         n_pf_q <= '0;
      end else begin
         n_rd_q <= n_rd_d;
         n_wr_q <= n_wr_d;
         n_pf_q <= n_pf_d;
      end
   end

   bus_cycles_counted_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      done_o |-> n_rd_q == res_q.reads && n_wr_q == res_q.writes && n_pf_q == res_q.prefetches)
      else $error("bus cycles do not match the reported counts");
   run_length_exact_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && ent.legal && total_clk == 6'h03 |=> run [*3] ##1 done_o)
      else $error("run length differs from the clock total");
   case_select_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && !req_i.overlap && req_i.cache_hit |=> res_q.tcase == CASE_CACHE)
      else $error("cache case not chosen");
   decimal_reg_worst_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.op == OP_DECIMAL_ADD_WITH_EXTEND && req_i.form == FORM_REG
      && !req_i.overlap && !req_i.cache_hit |=> res_q.clocks == 6'h05 && res_q.prefetches == 2'h1)
      else $error("decimal register worst case wrong");
   decimal_mem_cache_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.op == OP_DECIMAL_SUBTRACT_WITH_EXTEND && req_i.form == FORM_MEM
      && !req_i.overlap && req_i.cache_hit |=> res_q.clocks == 6'h10 && res_q.reads == 2'h2)
      else $error("decimal memory cache case wrong");
   binary_mem_best_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.op == OP_BINARY_ADD_WITH_EXTEND && req_i.form == FORM_MEM && req_i.overlap
      |=> res_q.clocks == 6'h0a && res_q.writes == 2'h1)
      else $error("binary memory best case wrong");
   compare_mem_cache_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.op == OP_MEMORY_COMPARE_POSTINCREMENT && req_i.form == FORM_MEM
      && !req_i.overlap && req_i.cache_hit |=> res_q.clocks == 6'h09 && res_q.writes == 2'h0)
      else $error("memory compare cache case wrong");
   expand_reg_worst_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.op == OP_DIGIT_EXPAND && req_i.form == FORM_REG
      && !req_i.overlap && !req_i.cache_hit |=> res_q.clocks == 6'h09)
      else $error("digit expand worst case wrong");
   zero_mem_calc_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.op == OP_ZERO_OPERAND && req_i.form == FORM_MEM && req_i.overlap
      |=> res_q.clocks == 6'h03 + $past(6'(req_i.ea_calc_clk)))
      else $error("zero memory add-on wrong");
   shift_dist_free_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.op == OP_ARITH_RIGHT_SHIFT && req_i.form != FORM_MEM && req_i.overlap
      |=> res_q.clocks == 6'h03)
      else $error("shift time depends on count form");
   rotx_reg_cache_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.op == OP_RIGHT_ROTATE_THROUGH_EXTEND && req_i.form == FORM_REG
      && !req_i.overlap && req_i.cache_hit |=> res_q.clocks == 6'h0c)
      else $error("rotate through extend cache case wrong");
   bit_mem_imm_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take && req_i.op == OP_SINGLE_BIT_TEST && req_i.form == FORM_MEM && req_i.overlap
      && !req_i.bitnum_from_reg |=> res_q.clocks == 6'h04 + $past(6'(req_i.imm_fetch_clk))
      && res_q.writes == 2'h0)
      else $error("bit test memory timing wrong");

endmodule : integer_op_cycle_timing

/* File: rtl/op_timing_pkg.sv */
package op_timing_pkg;
   localparam int CLK_W = 6;
   localparam int ADD_W = 5;
   localparam int CNT_W = 2;
   localparam logic [CNT_W-1:0] PF_WORST = 2'h1;
   localparam logic [CNT_W-1:0] CNT_NONE = 2'h0;
   localparam logic [CLK_W-1:0] CLK_NONE = 6'h00;
   localparam logic [CLK_W-1:0] CLK_ONE = 6'h01;

   typedef enum logic [4:0] {
      OP_DECIMAL_ADD_WITH_EXTEND = 5'h00,
      OP_DECIMAL_SUBTRACT_WITH_EXTEND = 5'h01,
      OP_BINARY_ADD_WITH_EXTEND = 5'h02,
      OP_BINARY_SUBTRACT_WITH_EXTEND = 5'h03,
      OP_MEMORY_COMPARE_POSTINCREMENT = 5'h04,
      OP_DIGIT_COMPRESS = 5'h05,
      OP_DIGIT_EXPAND = 5'h06,
      OP_ZERO_OPERAND = 5'h07,
      OP_TWOS_COMPLEMENT_OPERAND = 5'h08,
      OP_TWOS_COMPLEMENT_WITH_EXTEND = 5'h09,
      OP_ONES_COMPLEMENT = 5'h0a,
      OP_SIGN_WIDEN = 5'h0b,
      OP_DECIMAL_COMPLEMENT = 5'h0c,
      OP_SET_ON_CONDITION = 5'h0d,
      OP_ATOMIC_TEST_SET = 5'h0e,
      OP_COMPARE_WITH_ZERO = 5'h0f,
      OP_LOGICAL_LEFT_SHIFT = 5'h10,
      OP_LOGICAL_RIGHT_SHIFT = 5'h11,
      OP_ARITH_LEFT_SHIFT = 5'h12,
      OP_ARITH_RIGHT_SHIFT = 5'h13,
      OP_LEFT_ROTATE = 5'h14,
      OP_RIGHT_ROTATE = 5'h15,
      OP_LEFT_ROTATE_THROUGH_EXTEND = 5'h16,
      OP_RIGHT_ROTATE_THROUGH_EXTEND = 5'h17,
      OP_SINGLE_BIT_TEST = 5'h18,
      OP_SINGLE_BIT_TOGGLE = 5'h19,
      OP_SINGLE_BIT_ZERO = 5'h1a,
      OP_SINGLE_BIT_RAISE = 5'h1b
   } op_t;

   // FORM_DYN is a data register with the shift count held in a register
   typedef enum logic [1:0] {
      FORM_REG = 2'h0,
      FORM_DYN = 2'h1,
      FORM_MEM = 2'h2
   } form_t;

   typedef enum logic [1:0] {
      CASE_BEST = 2'h0,
      CASE_CACHE = 2'h1,
      CASE_WORST = 2'h2
   } case_t;

   typedef struct packed {
      op_t op;
      form_t form;
      logic bitnum_from_reg;
      logic overlap;
      logic cache_hit;
      logic [ADD_W-1:0] ea_calc_clk;
      logic [ADD_W-1:0] ea_fetch_clk;
      logic [ADD_W-1:0] imm_fetch_clk;
   } req_t;

   typedef struct packed {
      logic illegal;
      case_t tcase;
      logic [CLK_W-1:0] clocks;
      logic [CNT_W-1:0] reads;
      logic [CNT_W-1:0] prefetches;
      logic [CNT_W-1:0] writes;
   } res_t;

   typedef struct packed {
      logic legal;
      logic [ADD_W-1:0] best;
      logic [ADD_W-1:0] cache;
      logic [ADD_W-1:0] worst;
      logic [CNT_W-1:0] reads;
      logic [CNT_W-1:0] writes;
   } entry_t;
endpackage : op_timing_pkg
